// [hdl/cmbo_bus_unit.sv]
`timescale 1ns/100ps
// bus unit: multiplexed address/data, middle address and address/status outputs
module cmbo_bus_unit
  import cmbo_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic word_valid,
  input wire logic word_is_16,
  input wire cmbo_req_t word_req,
  input wire logic [CMBO_IW-1:0] word_wdata,
  output logic word_ready,
  output logic [CMBO_IW-1:0] word_rdata,
  output logic word_done,
  input wire logic irq_enable_flag,
  input wire logic int_ack,
  input wire logic hold_ack,
  input wire logic ready,
  input wire logic min_max_select,
  input wire logic [CMBO_DW-1:0] shared_low_addr_data_lines_in,
  output logic [CMBO_DW-1:0] shared_low_addr_data_lines_out,
  output logic shared_low_addr_data_lines_oe,
  output logic [7:0] middle_address_lines,
  output logic middle_address_lines_oe,
  output logic upper_addr_status_bit19,
  output logic upper_addr_status_bit18,
  output logic upper_addr_status_bit17,
  output logic upper_addr_status_bit16,
  output logic upper_addr_status_oe,
  output logic rd_n,
  output logic rd_oe,
  output logic min_mode
);
  typedef struct packed {
    cmbo_state_t st;
    cmbo_req_t cur;
    cmbo_pins_t pins;
    logic [CMBO_DW-1:0] rdata;
    logic done;
    logic ready_s1;
    logic ready_s2;
    logic mode_s1;
    logic mode_s2;
    logic min_mode;
    logic [3:0] waits;
  } cmbo_bus_t;

  cmbo_bus_t b_q, b_d;
  logic byte_valid;
  cmbo_req_t byte_req;
  logic floated;

  // status nibble: top bit low, interrupt flag, segment code
  function automatic logic [3:0] status_nibble(input logic ie, input logic [1:0] seg);
    status_nibble = {1'b0, ie, seg};
  endfunction

  cmbo_word_split u_split (
    .clk(clk),
    .nrst(nrst),
    .word_valid(word_valid),
    .word_is_16(word_is_16),
    .word_req(word_req),
    .word_wdata(word_wdata),
    .word_ready(word_ready),
    .byte_valid(byte_valid),
    .byte_req(byte_req),
    .byte_done(b_q.done),
    .byte_rdata(b_q.rdata),
    .word_rdata(word_rdata),
    .word_done(word_done)
  );

  assign floated = int_ack || hold_ack;

  always_comb
  begin
    b_d = b_q;
    b_d.done = 1'b0;
    b_d.ready_s1 = ready;
    b_d.ready_s2 = b_q.ready_s1;
    b_d.mode_s1 = min_max_select;
    b_d.mode_s2 = b_q.mode_s1;
    b_d.min_mode = b_q.mode_s2;
    unique case (b_q.st)
      CMBO_IDLE:
        // splitter needs the done edge to step to the next byte, else a byte runs twice
        if (byte_valid && !b_q.done && !floated)
        begin
          b_d.st = CMBO_ADDRESS_STATE;
          b_d.cur = byte_req;
        end
      CMBO_ADDRESS_STATE:
        b_d.st = CMBO_SECOND_BUS_STATE;
      CMBO_SECOND_BUS_STATE:
        b_d.st = CMBO_THIRD_BUS_STATE;
      CMBO_THIRD_BUS_STATE, CMBO_WAIT_STATE:
        if (b_q.ready_s2 || b_q.waits == 4'(CMBO_MAX_WAITS))
        begin
          b_d.st = CMBO_FINAL_BUS_STATE;
          b_d.waits = '0;
          b_d.rdata = shared_low_addr_data_lines_in;
        end
        else
        begin
          b_d.st = CMBO_WAIT_STATE;
          b_d.waits = b_q.waits + CMBO_WAIT_ONE;
        end
      CMBO_FINAL_BUS_STATE:
      begin
        b_d.st = CMBO_IDLE;
        b_d.done = 1'b1;
      end
    endcase

    // outputs are registered: they show the state being entered
    b_d.pins.ad_oe = 1'b0;
    b_d.pins.rd_n = 1'b1;
    b_d.pins.rd_oe = !floated;
    b_d.pins.mid_oe = !floated && (b_d.st != CMBO_IDLE);
    b_d.pins.upper_oe = !floated && (b_d.st != CMBO_IDLE);
    if (b_d.st != CMBO_IDLE)
      b_d.pins.mid_addr = b_d.cur.addr[15:8];
    if (b_d.st == CMBO_ADDRESS_STATE)
    begin
      b_d.pins.ad_out = b_d.cur.addr[7:0];
      b_d.pins.ad_oe = !floated;
      b_d.pins.upper = b_d.cur.is_io ? CMBO_IO_UPPER : b_d.cur.addr[19:16];
    end
    else if (b_d.st != CMBO_IDLE)
    begin
      b_d.pins.upper = status_nibble(irq_enable_flag, b_d.cur.seg);
      if (b_d.cur.is_read)
      begin
        // second state keeps the strobe high so the address has left the lines
        b_d.pins.rd_n = (b_d.st == CMBO_SECOND_BUS_STATE) ? (b_q.pins.ad_oe) : 1'b0;
      end
      else
      begin
        b_d.pins.ad_out = b_d.cur.wdata;
        b_d.pins.ad_oe = !floated;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      b_q <= '0;
      b_q.st <= CMBO_IDLE;
      b_q.pins.rd_n <= 1'b1;
      b_q.pins.ad_out <= CMBO_BYTE_ZERO;
    end
    else
      b_q <= b_d;
  end

  assign shared_low_addr_data_lines_out = b_q.pins.ad_out;
  assign shared_low_addr_data_lines_oe = b_q.pins.ad_oe;
  assign middle_address_lines = b_q.pins.mid_addr;
  assign middle_address_lines_oe = b_q.pins.mid_oe;
  assign upper_addr_status_bit19 = b_q.pins.upper[3];
  assign upper_addr_status_bit18 = b_q.pins.upper[2];
  assign upper_addr_status_bit17 = b_q.pins.upper[1];
  assign upper_addr_status_bit16 = b_q.pins.upper[0];
  assign upper_addr_status_oe = b_q.pins.upper_oe;
  assign rd_n = b_q.pins.rd_n;
  assign rd_oe = b_q.pins.rd_oe;
  assign min_mode = b_q.min_mode;

  AST_ADDR_FIRST: assert property (@(posedge clk) disable iff (!nrst)
    (b_q.st == CMBO_IDLE && b_d.st == CMBO_ADDRESS_STATE && !floated)
    |=> shared_low_addr_data_lines_oe && shared_low_addr_data_lines_out == b_q.cur.addr[7:0])
    else $error("low lines not carrying address in address state");
  AST_FLOAT: assert property (@(posedge clk) disable iff (!nrst)
    floated |=> !shared_low_addr_data_lines_oe && !middle_address_lines_oe)
    else $error("lines driven during acknowledge or hold");
  AST_MID_STABLE: assert property (@(posedge clk) disable iff (!nrst)
    (b_q.st == CMBO_SECOND_BUS_STATE) |-> $stable(middle_address_lines))
    else $error("middle address changed within cycle");
  AST_IO_LOW: assert property (@(posedge clk) disable iff (!nrst)
    (b_q.st == CMBO_ADDRESS_STATE && b_q.cur.is_io) |-> b_q.pins.upper == CMBO_IO_UPPER)
    else $error("upper lines not low in io cycle");
  AST_TOP_LOW: assert property (@(posedge clk) disable iff (!nrst)
    (b_q.st inside {CMBO_SECOND_BUS_STATE, CMBO_THIRD_BUS_STATE, CMBO_WAIT_STATE})
    |-> !upper_addr_status_bit19)
    else $error("top status bit high in status phase");
  AST_SEG: assert property (@(posedge clk) disable iff (!nrst)
    (b_q.st == CMBO_THIRD_BUS_STATE) |-> b_q.pins.upper[1:0] == b_q.cur.seg)
    else $error("segment status mismatch");
  AST_RD_LOW: assert property (@(posedge clk) disable iff (!nrst)
    (b_q.st == CMBO_THIRD_BUS_STATE && b_q.cur.is_read) |-> !rd_n)
    else $error("read strobe high in third state");
  AST_WAIT: assert property (@(posedge clk) disable iff (!nrst)
    (b_q.st == CMBO_THIRD_BUS_STATE && !b_q.ready_s2) |=> b_q.st == CMBO_WAIT_STATE)
    else $error("no wait state inserted");
  AST_FLOAT_REFUSE: assert property (@(posedge clk) disable iff (!nrst)
    (b_q.st == CMBO_IDLE && floated) |=> b_q.st == CMBO_IDLE)
    else $error("bus cycle started during acknowledge or hold");
  AST_IE_STATUS: assert property (@(posedge clk) disable iff (!nrst)
    (b_q.st inside {CMBO_SECOND_BUS_STATE, CMBO_THIRD_BUS_STATE, CMBO_WAIT_STATE,
    CMBO_FINAL_BUS_STATE}) |-> upper_addr_status_bit18 == $past(irq_enable_flag))
    else $error("interrupt enable status not refreshed");
endmodule

// [shared/cmbo_pkg.sv]
// package: bus states, widths, status encodings and carrier structs for the local bus outputs
package cmbo_pkg;
  localparam int CMBO_AW = 20;
  localparam int CMBO_DW = 8;
  localparam int CMBO_IW = 16;
  localparam int CMBO_MAX_WAITS = 15;
  localparam logic [1:0] CMBO_SEG_ALT = 2'h0;
  localparam logic [1:0] CMBO_SEG_STACK = 2'h1;
  localparam logic [1:0] CMBO_SEG_CODE = 2'h2;
  localparam logic [1:0] CMBO_SEG_DATA = 2'h3;
  localparam logic [3:0] CMBO_IO_UPPER = 4'h0;
  localparam logic [3:0] CMBO_WAIT_ONE = 4'h1;
  localparam logic [CMBO_DW-1:0] CMBO_BYTE_ZERO = 8'h00;

  typedef enum logic [2:0] {
    CMBO_IDLE,
    CMBO_ADDRESS_STATE,
    CMBO_SECOND_BUS_STATE,
    CMBO_THIRD_BUS_STATE,
    CMBO_WAIT_STATE,
    CMBO_FINAL_BUS_STATE
  } cmbo_state_t;

  // one byte transfer requested by the execution unit
  typedef struct packed {
    logic [CMBO_AW-1:0] addr;
    logic [CMBO_DW-1:0] wdata;
    logic is_io;
    logic is_read;
    logic [1:0] seg;
  } cmbo_req_t;

  // pin group as seen at the package edge
  typedef struct packed {
    logic [CMBO_DW-1:0] ad_out;
    logic ad_oe;
    logic [7:0] mid_addr;
    logic mid_oe;
    logic [3:0] upper;
    logic upper_oe;
    logic rd_n;
    logic rd_oe;
  } cmbo_pins_t;
endpackage

// [hdl/cmbo_word_split.sv]
`timescale 1ns/100ps
// word splitter: turns a 16-bit operand into successive byte requests, low byte first
module cmbo_word_split
  import cmbo_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic word_valid,
  input wire logic word_is_16,
  input wire cmbo_req_t word_req,
  input wire logic [CMBO_IW-1:0] word_wdata,
  output logic word_ready,
  output logic byte_valid,
  output cmbo_req_t byte_req,
  input wire logic byte_done,
  input wire logic [CMBO_DW-1:0] byte_rdata,
  output logic [CMBO_IW-1:0] word_rdata,
  output logic word_done
);
  typedef struct packed {
    logic busy;
    logic second;
    logic is_16;
    cmbo_req_t req;
    logic [CMBO_DW-1:0] hi_wdata;
    logic [CMBO_IW-1:0] rdata;
    logic done;
    logic ready;
  } cmbo_split_t;

  cmbo_split_t s_q, s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (!s_q.busy && word_valid)
    begin
      s_d.busy = 1'b1;
      s_d.second = 1'b0;
      s_d.is_16 = word_is_16;
      s_d.req = word_req;
      s_d.req.wdata = word_wdata[CMBO_DW-1:0];
      s_d.hi_wdata = word_wdata[CMBO_IW-1:CMBO_DW];
    end
    else if (s_q.busy && byte_done)
    begin
      // external path is one byte wide, so a word costs two bus cycles
      if (!s_q.second)
        s_d.rdata[CMBO_DW-1:0] = byte_rdata;
      else
        s_d.rdata[CMBO_IW-1:CMBO_DW] = byte_rdata;
      if (s_q.is_16 && !s_q.second)
      begin
        s_d.second = 1'b1;
        s_d.req.addr = s_q.req.addr + CMBO_AW'(1);
        s_d.req.wdata = s_q.hi_wdata;
      end
      else
      begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
    end
    // ready kept in its own flop so the port is not an inverter output
    s_d.ready = !s_d.busy;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_q <= '0;
      s_q.ready <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign word_ready = s_q.ready;
  assign byte_valid = s_q.busy;
  assign byte_req = s_q.req;
  assign word_rdata = s_q.rdata;
  assign word_done = s_q.done;
endmodule

// [testbench/cmbo_mem_model.sv]
// partner model: memory and I/O responder on the multiplexed local bus
`timescale 1ns/100ps
module cmbo_mem_model
  import cmbo_pkg::*;
(
  input wire logic clk,
  input wire logic upper_oe,
  input wire logic [7:0] ad_out,
  input wire logic [7:0] mid,
  input wire logic rd_n,
  input wire logic [3:0] waits,
  output logic [CMBO_DW-1:0] ad_in,
  output logic ready
);
  logic [15:0] addr_q = 16'h0000;
  logic [3:0] cnt_q = 4'h0;
  logic oe_q = 1'b0;
  logic [7:0] tog_q = 8'h00;
  always @(posedge clk)
  begin
    oe_q <= upper_oe;
    tog_q <= ~ad_in;
    if (upper_oe && !oe_q)
    begin
      addr_q <= {mid, ad_out};
      cnt_q <= 4'h0;
    end
    else if (cnt_q != 4'hF)
      cnt_q <= cnt_q + 4'h1;
  end
  // released bus flips every cycle so a stale byte never passes for data
  assign ad_in = rd_n ? tog_q : (addr_q[7:0] ^ 8'h5A);
  // ready passes two flops in the unit, so it must drop while the address is still out
  assign ready = (waits == 4'h0) || (cnt_q >= waits && !(upper_oe && !oe_q));
endmodule

// [testbench/test_cpu_muxed_local_bus_outputs.sv]
// testbench: byte, word, I/O and write cycles, wait states and bus float
`timescale 1ns/100ps
module test_cpu_muxed_local_bus_outputs;
  import cmbo_pkg::*;
  logic clk = 0, nrst = 0, wv = 0, w16 = 0, irq = 0, iack = 0, hack = 0, mms = 1;
  cmbo_req_t req = '0;
  logic [15:0] wd = 16'h0000;
  logic [3:0] waits = 4'h0;
  logic [7:0] ad_in, ado, mid;
  logic wr, done, aoe, moe, u19, u18, u17, u16, uoe, rdn, roe, minm, rdy, seen = 0;
  logic [15:0] rdat;
  int mismatches = 0, checks = 0, cyc = 0, n0, n3;
  cmbo_bus_unit uut (.clk(clk), .nrst(nrst), .word_valid(wv), .word_is_16(w16),
    .word_req(req), .word_wdata(wd), .word_ready(wr), .word_rdata(rdat), .word_done(done),
    .irq_enable_flag(irq), .int_ack(iack), .hold_ack(hack), .ready(rdy),
    .min_max_select(mms), .shared_low_addr_data_lines_in(ad_in),
    .shared_low_addr_data_lines_out(ado), .shared_low_addr_data_lines_oe(aoe),
    .middle_address_lines(mid), .middle_address_lines_oe(moe),
    .upper_addr_status_bit19(u19), .upper_addr_status_bit18(u18),
    .upper_addr_status_bit17(u17), .upper_addr_status_bit16(u16),
    .upper_addr_status_oe(uoe), .rd_n(rdn), .rd_oe(roe), .min_mode(minm));
  cmbo_mem_model mem (.clk(clk), .upper_oe(uoe), .ad_out(ado), .mid(mid), .rd_n(rdn),
    .waits(waits), .ad_in(ad_in), .ready(rdy));
  initial
  begin
    forever #50 clk = ~clk;
  end
  task test_done;
    if (mismatches == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [19:0] got, input logic [19:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // sampled mid-cycle so a registered pulse is never read in its launching time step
  always @(negedge clk)
  begin
    cyc++;
    if (done === 1'b1)
      seen = 1;
    if (cyc == 2000)
    begin
      mismatches++;
      test_done;
    end
  end
  // one transfer; counts cycles with the read strobe low
  task automatic xfer(input logic [19:0] a, input logic io, rd, wide,
    input logic [1:0] sg, output int n);
    logic [19:0] b;
    logic first;
    int k;
    n = 0;
    k = 0;
    seen = 0;
    while (wr !== 1'b1 && k < 50)
    begin
      @(posedge clk);
      #1 k++;
    end
    req = '{addr: a, wdata: 8'h00, is_io: io, is_read: rd, seg: sg};
    w16 = wide;
    wv = 1;
    @(posedge clk);
    #1 wv = 0;
    for (int i = 0; i <= wide; i++)
    begin
      b = a + i;
      k = 0;
      while (uoe !== 1'b1 && k < 50)
      begin
        @(posedge clk);
        #1 k++;
      end
      chk(ado, b[7:0]);
      chk(mid, b[15:8]);
      chk({u19, u18, u17, u16}, io ? CMBO_IO_UPPER : b[19:16]);
      chk({aoe, roe, moe}, 3'h7);
      first = 1;
      forever
      begin
        @(posedge clk);
        #1;
        if (uoe !== 1'b1)
          break;
        chk({u19, u18, u17, u16}, {1'b0, irq, sg});
        irq = ~irq;
        chk(mid, b[15:8]);
        if (first || !rd)
          chk(rdn, 1'b1);
        if (!rd)
          chk(ado, wd[8*i +: 8]);
        chk(aoe, !rd);
        n += (rdn === 1'b0);
        first = 0;
      end
    end
    k = 0;
    while (!seen && k < 20)
    begin
      @(posedge clk);
      #1 k++;
    end
    chk(seen, 1'b1);
    if (rd)
      chk(wide ? rdat : rdat[7:0], wide ? {b[7:0] ^ 8'h5A, a[7:0] ^ 8'h5A} : a[7:0] ^ 8'h5A);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    #1 nrst = 1;
    for (int s = 0; s < 4; s++)
      xfer(20'hA5C30 + s, 0, 1, 0, s[1:0], n0);
    chk(minm, 1'b1);
    xfer(20'h3C7F1, 1, 1, 0, CMBO_SEG_CODE, n0);
    wd = 16'h9EC6;
    xfer(20'h12345, 0, 0, 1, CMBO_SEG_STACK, n0);
    xfer(20'hFFFFE, 0, 1, 1, CMBO_SEG_DATA, n0);
    xfer(20'h0BEEF, 0, 1, 0, CMBO_SEG_ALT, n0);
    waits = 4'h3;
    xfer(20'h0BEEF, 0, 1, 0, CMBO_SEG_ALT, n3);
    chk(n3 > n0, 1'b1);
    for (int f = 0; f < 2; f++)
    begin
      iack = (f == 0);
      hack = (f == 1);
      fork
        xfer(20'h0BEEF, 0, 1, 0, CMBO_SEG_ALT, n0);
        begin
          repeat (3) @(posedge clk);
          #1 chk({aoe, moe, uoe, roe}, 4'h0);
          chk(mid, 8'hBE);
          iack = 0;
          hack = 0;
        end
      join
    end
    mms = 0;
    repeat (4) @(posedge clk);
    #1 chk(minm, 1'b0);
    test_done;
  end
endmodule
